// >>> spk_buf.sv
/*
  spk_buf: character buffer, one write port and one read port, registered read data.
  Assumes the writer never addresses beyond DEPTH-1.
*/
`timescale 1ns/1ps
module spk_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH < 2)
  begin : g_bad
    $error("spk_buf: DEPTH must be at least 2");
  end

  // no reset: contents are only read after being written
  always_ff @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : spk_buf

// >>> spk_packetizer.sv
/*
  spk_packetizer: gathers serial characters into a buffer and releases them as packets,
  plus connection keep-alive supervision. Registers on APB.
  Assumes rx_valid/rx_data and the network handshakes are synchronous to pclk.
*/
// The register offsets and the APB interface to the registers were decided locally.
// Overview of operation
// - length limit zero: release only on marker, idle timeout or full buffer
// - length limit 1..1024: release when buffered count reaches the limit
// - markers are 8-bit values; single marker alone triggers packing
// - two markers: trigger only when first is directly followed by second
// - with markers on, keep collecting until full or marker sequence seen
// - marker handling mode is ignored while first marker disabled
// - pass-through mode packs at once, markers kept
// - plus-one mode packs after exactly one further character
// - plus-two mode packs after two further characters
// - strip mode packs at once with marker characters removed
// - idle timeout zero: never flush on idleness
// - idle timeout 1..65535 ms: flush after that long without data
// - send periodic keep-alive probes; wait 0..99 minutes, default 7
// - wait zero keeps link open; else close when no answer in time
`timescale 1ns/1ps
module spk_packetizer #(
  parameter int unsigned BUF_DEPTH = spk_pkg::MAX_LEN,
  parameter int unsigned CYC_MS    = spk_pkg::CYC_PER_MS,
  parameter int unsigned MIN_MS    = spk_pkg::MIN_MS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  output logic                   rx_ready,
  output logic                   pkt_valid,
  output spk_pkg::spk_beat_t     pkt,
  input  wire logic              pkt_ready,
  input  wire logic              conn_up,
  input  wire logic              ka_resp,
  output logic                   ka_probe,
  output logic                   conn_close
);
  import spk_pkg::*;
  localparam int AW = $clog2(BUF_DEPTH);
  if (BUF_DEPTH < 2 || BUF_DEPTH > 2 ** LEN_W - 1 || CYC_MS < 2 || MIN_MS < 1)
  begin : g_bad
    $error("spk_packetizer: unsupported parameter value");
  end
  spk_cfg_t          cfg_r;
  spk_state_t        state_r;
  spk_state_t        state_nxt;
  logic [LEN_W-1:0]  cnt_r;
  logic [LEN_W-1:0]  pkt_len_r;
  logic [LEN_W-1:0]  rd_ptr_r;
  logic [1:0]        extra_r;
  logic              prev_d1_r;
  logic [IDLE_W-1:0] idle_ms_r;
  logic [KA_W-1:0]   ka_min_r;
  logic [7:0]        mem_rdata;
  logic              ms_tick;
  logic              min_tick;
  // APB decode
  wire setup   = psel && !penable;
  wire wr_go   = psel && penable && pready && pwrite;
  wire sel_ctl = paddr == OFS_CTRL;
  wire sel_mrk = paddr == OFS_MARK;
  wire sel_idl = paddr == OFS_IDLE;
  wire sel_kep = paddr == OFS_KEEP;
  wire sel_sta = paddr == OFS_STAT;
  wire map_ok  = sel_ctl || sel_mrk || sel_idl || sel_kep || sel_sta;
  wire busy    = state_r != ST_COLLECT;
  wire [31:0] rd_mux =
    sel_ctl ? {12'h000, cfg_r.mode, cfg_r.d2_en, cfg_r.d1_en, 5'h00, cfg_r.flush_len} :
    sel_mrk ? {16'h0000, cfg_r.d2, cfg_r.d1} :
    sel_idl ? {16'h0000, cfg_r.idle_ms} :
    sel_kep ? {25'h0000000, cfg_r.ka_min} :
    sel_sta ? {13'h0000, extra_r, busy, 5'h00, cnt_r} : 32'h00000000;
  // receive side decisions
  wire              acc       = rx_valid && rx_ready;
  wire [LEN_W-1:0]  cnt_inc   = cnt_r + 1'b1;
  wire [LEN_W-1:0]  mlen      = cfg_r.d2_en ? 11'h002 : 11'h001;
  wire              mk_pair   = prev_d1_r && rx_data == cfg_r.d2;
  wire              mk_one    = rx_data == cfg_r.d1;
  // a marker seen while already waiting for trailing characters is plain data
  wire              hit       = acc && cfg_r.d1_en && extra_r == 2'h0 &&
                                (cfg_r.d2_en ? mk_pair : mk_one);
  wire              hit_now   = hit && (cfg_r.mode == MD_NONE || cfg_r.mode == MD_STRIP);
  wire              strip     = hit && cfg_r.mode == MD_STRIP;
  wire              extra_end = acc && extra_r == 2'h1;
  wire              len_fire  = acc && cfg_r.flush_len != LEN_RST &&
                                cnt_inc >= cfg_r.flush_len;
  wire              full_fire = acc && cnt_inc == LEN_W'(BUF_DEPTH);
  wire              idle_fire = state_r == ST_COLLECT && !acc && cnt_r != LEN_RST &&
                                cfg_r.idle_ms != IDLE_RST &&
                                idle_ms_r >= cfg_r.idle_ms;
  wire              fire      = len_fire || full_fire || hit_now || extra_end || idle_fire;
  wire [LEN_W-1:0]  fire_len  = !acc ? cnt_r : strip ? cnt_inc - mlen : cnt_inc;
  wire              beat_done = state_r == ST_SEND && pkt_valid && pkt_ready;
  wire              ka_expire = conn_up && cfg_r.ka_min != '0 && ka_min_r >= cfg_r.ka_min;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_COLLECT: if (fire && fire_len != LEN_RST) state_nxt = ST_FETCH;
      ST_FETCH:   state_nxt = ST_LOAD;
      ST_LOAD:    state_nxt = ST_SEND;
      ST_SEND:    if (beat_done) state_nxt = pkt.last ? ST_COLLECT : ST_FETCH;
    endcase
  end

  spk_buf #(.W (8), .DEPTH (BUF_DEPTH), .AW (AW)) u_buf (
    .pclk  (pclk),
    .we    (acc),
    .waddr (cnt_r[AW-1:0]),
    .wdata (rx_data),
    .raddr (rd_ptr_r[AW-1:0]),
    .rdata (mem_rdata)
  );

  // idle clock restarts with each character so the timeout is measured from it
  spk_tick #(.CYCLES (CYC_MS)) u_ms (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (acc),
    .tick    (ms_tick)
  );

  spk_tick #(.CYCLES (CYC_MS * MIN_MS)) u_min (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (1'b0),
    .tick    (min_tick)
  );

  // APB slave: answers in the first access cycle; reads are sampled at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !map_ok;
      if (setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r <= CFG_RST;
    else if (wr_go)
    begin
      if (sel_ctl)
      begin
        cfg_r.flush_len <= pwdata[CTRL_LEN_LSB +: LEN_W];
        cfg_r.d1_en     <= pwdata[CTRL_D1EN_BIT];
        cfg_r.d2_en     <= pwdata[CTRL_D2EN_BIT];
        cfg_r.mode      <= spk_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
      end
      if (sel_mrk)
      begin
        cfg_r.d1 <= pwdata[MARK_D1_LSB +: 8];
        cfg_r.d2 <= pwdata[MARK_D2_LSB +: 8];
      end
      if (sel_idl)
        cfg_r.idle_ms <= pwdata[IDLE_LSB +: IDLE_W];
      if (sel_kep)
        cfg_r.ka_min <= pwdata[KEEP_LSB +: KA_W];
    end
  end

  // collection state; count and marker tracking are cleared and the length captured when a packet is decided
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r   <= ST_COLLECT;
      rx_ready  <= 1'b1;
      cnt_r     <= LEN_RST;
      pkt_len_r <= LEN_RST;
      prev_d1_r <= 1'b0;
      extra_r   <= 2'h0;
    end
    else
    begin
      state_r  <= state_nxt;
      rx_ready <= state_nxt == ST_COLLECT;
      if (fire)
      begin
        cnt_r     <= LEN_RST;
        pkt_len_r <= fire_len;
        prev_d1_r <= 1'b0;
        extra_r   <= 2'h0;
      end
      else if (acc)
      begin
        cnt_r     <= cnt_inc;
        prev_d1_r <= mk_one;
        if (extra_r != 2'h0)
          extra_r <= extra_r - 1'b1;
        else if (hit)
          extra_r <= cfg_r.mode == MD_PLUS2 ? 2'h2 : 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_ms_r <= IDLE_RST;
    else if (acc || fire)
      idle_ms_r <= IDLE_RST;
    else if (ms_tick && !(&idle_ms_r))
      idle_ms_r <= idle_ms_r + 1'b1;
  end

  // drain: one byte every three cycles at best, limited by the registered read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ptr_r  <= LEN_RST;
      pkt_valid <= 1'b0;
      pkt       <= '0;
    end
    else
    begin
      if (fire)
        rd_ptr_r <= LEN_RST;
      else if (beat_done)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (state_r == ST_LOAD)
      begin
        pkt_valid <= 1'b1;
        pkt       <= '{last: rd_ptr_r == pkt_len_r - 1'b1, data: mem_rdata};
      end
      else if (beat_done)
        pkt_valid <= 1'b0;
    end
  end

  // keep-alive: probe each minute, count minutes since the last answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ka_min_r   <= '0;
      ka_probe   <= 1'b0;
      conn_close <= 1'b0;
    end
    else
    begin
      ka_probe   <= conn_up && min_tick;
      conn_close <= ka_expire;
      if (!conn_up || ka_resp || ka_expire)
        ka_min_r <= '0;
      else if (min_tick && !(&ka_min_r))
        ka_min_r <= ka_min_r + 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_plus_arm(spk_mode_t m);
    hit && cfg_r.mode == m && !len_fire && !full_fire;
  endsequence
  property p_len;
    acc && cfg_r.flush_len != LEN_RST && cnt_inc >= cfg_r.flush_len |=> !rx_ready && cnt_r == LEN_RST;
  endproperty
  a_len: assert property (p_len) else $error("length limit did not release");
  property p_nolen;
    acc && cfg_r.flush_len == LEN_RST && !cfg_r.d1_en && extra_r == 2'h0 &&
    cnt_inc != LEN_W'(BUF_DEPTH) |=> rx_ready && cnt_r == $past(cnt_inc);
  endproperty
  a_nolen: assert property (p_nolen) else $error("release without cause");
  property p_single;
    acc && cfg_r.d1_en && !cfg_r.d2_en && extra_r == 2'h0 && rx_data == cfg_r.d1 &&
    cfg_r.mode == MD_NONE |=> pkt_len_r == $past(cnt_inc) && state_r == ST_FETCH ##2 pkt_valid;
  endproperty
  a_single: assert property (p_single) else $error("single marker not packed");
  property p_pair_only;
    acc && cfg_r.d1_en && cfg_r.d2_en && !prev_d1_r && cfg_r.flush_len == LEN_RST &&
    extra_r == 2'h0 && cnt_inc != LEN_W'(BUF_DEPTH) |=> rx_ready;
  endproperty
  a_pair_only: assert property (p_pair_only) else $error("second marker packed alone");
  property p_plus1;
    s_plus_arm(MD_PLUS1) |=> extra_r == 2'h1 && rx_ready;
  endproperty
  a_plus1: assert property (p_plus1) else $error("plus-one did not wait");
  // characters may be spaced out, so the first trailing one is found by its wait count
  property p_plus2;
    s_plus_arm(MD_PLUS2) ##[1:64] (acc && extra_r == 2'h2 && !len_fire && !full_fire)
      |=> extra_r == 2'h1 && rx_ready;
  endproperty
  a_plus2: assert property (p_plus2) else $error("plus-two released early");
  property p_extra_end;
    acc && extra_r == 2'h1 |=> cnt_r == LEN_RST && pkt_len_r == $past(cnt_inc);
  endproperty
  a_extra_end: assert property (p_extra_end) else $error("trailing char not packed");
  property p_strip;
    strip |=> pkt_len_r == $past(cnt_inc) - $past(mlen);
  endproperty
  a_strip: assert property (p_strip) else $error("markers not stripped");
  property p_no_idle;
    state_r == ST_COLLECT && !acc && cfg_r.idle_ms == IDLE_RST |=> state_r == ST_COLLECT;
  endproperty
  a_no_idle: assert property (p_no_idle) else $error("idle flush while disabled");
  property p_idle_restart;
    acc |=> idle_ms_r == IDLE_RST;
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("idle timer not restarted");
  property p_ka_zero;
    cfg_r.ka_min == '0 && $past(cfg_r.ka_min) == '0 |-> !conn_close;
  endproperty
  a_ka_zero: assert property (p_ka_zero) else $error("close with zero wait");
  property p_probe;
    conn_up && min_tick |=> ka_probe;
  endproperty
  a_probe: assert property (p_probe) else $error("keep-alive probe missing");
endmodule : spk_packetizer

// >>> spk_pkg.sv
/*
  spk_pkg: shared constants and types for the serial receive packetizer.
  Assumes one 25 MHz clock and an APB register port with 32-bit data.
*/
package spk_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MARK = 8'h04;
  localparam logic [7:0] OFS_IDLE = 8'h08;
  localparam logic [7:0] OFS_KEEP = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // field positions
  localparam int CTRL_LEN_LSB  = 0;
  localparam int CTRL_D1EN_BIT = 16;
  localparam int CTRL_D2EN_BIT = 17;
  localparam int CTRL_MODE_LSB = 18;
  localparam int MARK_D1_LSB   = 0;
  localparam int MARK_D2_LSB   = 8;
  localparam int IDLE_LSB      = 0;
  localparam int KEEP_LSB      = 0;

  // widths and limits
  localparam int LEN_W   = 11;
  localparam int IDLE_W  = 16;
  localparam int KA_W    = 7;
  localparam int MAX_LEN = 1024;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_MS        = 60000;

  typedef enum logic [1:0] {MD_NONE, MD_PLUS1, MD_PLUS2, MD_STRIP} spk_mode_t;

  typedef enum logic [1:0] {ST_COLLECT, ST_FETCH, ST_LOAD, ST_SEND} spk_state_t;

  typedef struct packed {
    logic [LEN_W-1:0]  flush_len;
    logic              d1_en;
    logic              d2_en;
    spk_mode_t         mode;
    logic [7:0]        d1;
    logic [7:0]        d2;
    logic [IDLE_W-1:0] idle_ms;
    logic [KA_W-1:0]   ka_min;
  } spk_cfg_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } spk_beat_t;

  // reset values
  localparam logic [LEN_W-1:0]  LEN_RST  = 11'h000;
  localparam logic [IDLE_W-1:0] IDLE_RST = 16'h0000;
  localparam logic [KA_W-1:0]   KA_RST   = 7'h07;
  localparam logic [7:0]        MARK_RST = 8'h00;

  localparam spk_cfg_t CFG_RST = '{flush_len: LEN_RST, d1_en: 1'b0, d2_en: 1'b0, mode: MD_NONE,
                                   d1: MARK_RST, d2: MARK_RST, idle_ms: IDLE_RST, ka_min: KA_RST};
endpackage : spk_pkg

// >>> spk_src.sv
/*
  spk_src: model of the attached serial device, one character per rx handshake.
  Assumes the packetizer samples rx_valid and rx_data on rising pclk edges.
*/
`timescale 1ns/1ps
module spk_src (
  input  wire logic       pclk,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  // gap models a slow line; the character is held until it is taken
  task automatic send(input logic [7:0] b, input int gap);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    // released line shows the inverse so a stale byte never passes as data
    rx_data  <= ~b;
    repeat (gap) @(posedge pclk);
  endtask : send
endmodule : spk_src

// >>> spk_tick.sv
/*
  spk_tick: divider giving a one-cycle enable every CYCLES clocks.
  Assumes clr restarts the period, so the first tick comes CYCLES clocks after it.
*/
`timescale 1ns/1ps
module spk_tick #(
  parameter int unsigned CYCLES = 25000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clr,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_r;

  if (CYCLES < 2)
  begin : g_bad
    $error("spk_tick: CYCLES must be at least 2");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (clr || cnt_r == CW'(CYCLES - 1))
    begin
      cnt_r <= '0;
      tick  <= !clr;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule : spk_tick

// >>> testbench.sv
/*
  testbench: APB configuration, serial source model and a stalling packet sink.
  Assumes the packetizer answers APB with pready and drains packets byte by byte.
*/
`timescale 1ns/1ps
module testbench;
  import spk_pkg::*;
  localparam int CM = 4;
  localparam int MM = 3;
  localparam int BD = 16;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr, rx_data;
  logic [31:0]      pwdata, prdata;
  logic             rx_valid, rx_ready, pkt_valid, ka_probe, conn_close, conn_up;
  logic             pkt_ready = 1'b1;
  logic             ka_resp   = 1'b0;
  logic             answer;
  spk_beat_t        pkt;
  logic [7:0]       got[$];
  int               plen[$];
  int               cyc, cur, lastp, per, nclose, error_cnt, tests_run;

  spk_packetizer #(.BUF_DEPTH(BD), .CYC_MS(CM), .MIN_MS(MM)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .pkt_valid(pkt_valid),
    .pkt(pkt), .pkt_ready(pkt_ready), .conn_up(conn_up), .ka_resp(ka_resp),
    .ka_probe(ka_probe), .conn_close(conn_close));

  spk_src src (.pclk(pclk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // sink stalls one cycle in five so some bytes see back-pressure
  always @(posedge pclk)
  begin
    cyc       <= cyc + 1;
    pkt_ready <= (cyc % 5) != 2;
    ka_resp   <= ka_probe & answer;
    if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
    begin
      got.push_back(pkt.data);
      cur = cur + 1;
      if (pkt.last === 1'b1)
      begin
        plen.push_back(cur);
        cur = 0;
      end
    end
    if (ka_probe === 1'b1)
    begin
      per   <= cyc - lastp;
      lastp <= cyc;
    end
    if (conn_close === 1'b1)
      nclose <= nclose + 1;
  end

  task automatic fail(input string m);
    error_cnt++;
    $display("ERROR %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
      fail($sformatf("got %h want %h", g, e));
  endtask : chk

  task automatic chk_pkt(input logic [7:0] e[$]);
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    while (plen.size() == 0 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    tests_run++;
    if (plen.size() == 0)
      fail("no packet");
    else
    begin
      n = plen.pop_front();
      bad = (n != e.size());
      for (int i = 0; i < n; i++)
        if (got.pop_front() !== e[i % e.size()])
          bad = 1'b1;
      if (bad)
        fail("packet content or length");
    end
  endtask : chk_pkt

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  task automatic tx(input logic [7:0] q[$]);
    foreach (q[i])
      src.send(q[i], 0);
  endtask : tx

  function automatic logic [31:0] cfg(int len, int d1, int d2, int m);
    return {12'h000, m[1:0], d2[0], d1[0], 5'h00, len[10:0]};
  endfunction : cfg

  task finish_test;
    $display("TB: errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    logic [7:0]  s[$];
    logic [7:0]  x[$];
    logic [31:0] q;
    logic        e;
    int          c0;
    {presetn, psel, penable, pwrite, paddr, pwdata, conn_up, answer} = '0;
    {cyc, cur, lastp, per, nclose, error_cnt, tests_run} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, q, e);
    chk(q, 32'h0);
    rd(OFS_IDLE, q, e);
    chk(q, 32'h0);
    rd(OFS_KEEP, q, e);
    chk(q, 32'h7);
    rd(8'h14, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(OFS_CTRL, cfg(1, 0, 0, 0));
    tx('{8'h55});
    chk_pkt('{8'h55});
    rd(OFS_STAT, q, e);
    chk(q, 32'h0);
    wr(OFS_CTRL, cfg(3, 0, 0, 0));
    tx('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    chk_pkt('{8'h01, 8'h02, 8'h03});
    chk_pkt('{8'h04, 8'h05, 8'h06});
    wr(OFS_CTRL, cfg(2, 0, 0, 3));
    tx('{8'h0d, 8'h41});
    chk_pkt('{8'h0d, 8'h41});
    wr(OFS_CTRL, cfg(0, 0, 0, 0));
    tx('{8'h77});
    repeat (60) @(posedge pclk);
    chk(rx_ready, 32'h1);
    rd(OFS_STAT, q, e);
    chk(q, 32'h1);
    wr(OFS_CTRL, cfg(2, 0, 0, 0));
    tx('{8'h78});
    chk_pkt('{8'h77, 8'h78});
    wr(OFS_MARK, 32'h0000_0a0d);
    for (int m = 0; m < 4; m++)
    begin
      s = '{8'h41, 8'h0d};
      if (m == 1 || m == 2)
        s.push_back(8'h0d);
      if (m == 2)
        s.push_back(8'h44);
      x = s;
      if (m == 3)
        void'(x.pop_back());
      wr(OFS_CTRL, cfg(0, 1, 0, m));
      tx(s);
      chk_pkt(x);
    end
    wr(OFS_CTRL, cfg(0, 1, 1, 0));
    tx('{8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a});
    chk_pkt('{8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a});
    wr(OFS_CTRL, cfg(0, 1, 1, 3));
    tx('{8'h41, 8'h0d, 8'h0a});
    chk_pkt('{8'h41});
    wr(OFS_CTRL, cfg(0, 1, 0, 0));
    s = {};
    for (int i = 0; i < BD; i++)
      s.push_back(8'(8'h20 + i));
    tx(s);
    chk_pkt(s);
    // two ms is eight cycles here, just above the seven-cycle spacing of the two characters
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IDLE, 32'h2);
    tx('{8'h61});
    repeat (5) @(posedge pclk);
    tx('{8'h62});
    repeat (5) @(posedge pclk);
    chk(rx_ready, 32'h1);
    chk_pkt('{8'h61, 8'h62});
    wr(OFS_IDLE, 32'h0);
    wr(OFS_KEEP, 32'h2);
    answer  <= 1'b1;
    conn_up <= 1'b1;
    repeat (100) @(posedge pclk);
    chk(per, MM * CM);
    chk(nclose, 32'h0);
    answer <= 1'b0;
    c0 = nclose;
    repeat (100) @(posedge pclk);
    chk(nclose > c0, 32'h1);
    wr(OFS_KEEP, 32'h0);
    repeat (4) @(posedge pclk);
    c0 = nclose;
    repeat (100) @(posedge pclk);
    chk(nclose - c0, 32'h0);
    finish_test;
  end

  initial
  begin
    #800000;
    error_cnt++;
    finish_test;
  end
endmodule : testbench
